/* src/rtc_alarm_calibration.sv */
// Purpose: Real-time clock with time-of-day and subsecond alarms and trim
// Assumes: rtc_clk_i is a free 32.768 kHz square wave, much slower than clk_i
// Notes:   Registers on Avalon-MM, one wait state on every access
`timescale 1ns/10ps
`default_nettype none
`include "rtc_params.svh"
module rtc_alarm_calibration (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        rtc_clk_i,
  output logic             irq_o,
  output logic             wake_o,
  output logic             calibration_square_output_o,
  output logic             calibration_square_output_oe_o
);
  import rtc_pkg::*;

  rtc_tick_if tb ();

  bus_state_t              bus_q;
  logic [2:0]              sync_q;
  logic [31:0]             seconds_q;
  logic [`RTC_SUB_W-1:0]   subsec_q;
  logic [31:0]             tod_alarm_q;
  logic [31:0]             tod_period_q;
  logic                    tod_armed_q;
  logic [31:0]             ss_reload_q;
  logic [31:0]             ss_count_q;
  logic                    ss_armed_q;
  logic [`RTC_CTRL_W-1:0]  ctrl_q;
  trim_t                   trim_q;
  logic [`RTC_EV_W-1:0]    stat_q;
  logic [`RTC_EV_W-1:0]    int_en_q;
  logic [`RTC_EV_W-1:0]    ev;
  logic                    tick;
  logic                    wrap;
  logic                    tod_fire;
  logic                    ss_fire;
  logic                    wr;
  logic                    rd;
  logic [31:0]             rd_mux;

  // Register address match, used by both the write and read paths
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Clamp so that the trim never leaves the plus or minus 127 range
  function automatic trim_t clamp_trim(input logic [7:0] v);
    clamp_trim = (v == 8'h80) ? trim_t'(`RTC_TRIM_MIN) : trim_t'(v);
  endfunction : clamp_trim

  // Avalon handshake: one wait cycle, then the access completes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_q <= BUS_IDLE;
    end else begin
      unique case (bus_q)
        BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_q <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          bus_q <= BUS_IDLE;
        end
      endcase
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (bus_q == BUS_IDLE);
  assign wr = avs_write_i && (bus_q == BUS_ACK);
  assign rd = avs_read_i && (bus_q == BUS_IDLE);

  // Two flops before any logic, third flop only for the edge detect
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], rtc_clk_i};
    end
  end

  assign tb.edge_32k = sync_q[1] & ~sync_q[2] & ctrl_q[`RTC_CTRL_RUN];
  assign tb.trim     = trim_q;
  assign tb.cal_en   = ctrl_q[`RTC_CTRL_CAL_EN];
  assign tick        = tb.tick;

  rtc_tick_gen u_tick_gen (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tb    (tb)
  );

  rtc_cal_out u_cal_out (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tb    (tb),
    .sq_o  (calibration_square_output_o),
    .oe_o  (calibration_square_output_oe_o)
  );

  // Subsecond wrap is the carry into seconds
  assign wrap = tick && (subsec_q == `RTC_SUB_LAST);

  // Subsecond counter; a software write wins over a tick in the same cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      subsec_q <= 12'h000;
    end else if (wr && hit(avs_address_i, `RTC_OFS_SUBSEC)) begin
      subsec_q <= avs_writedata_i[`RTC_SUB_W-1:0];
    end else if (tick) begin
      subsec_q <= subsec_q + 12'h001;
    end
  end

  // Seconds count; calendar work is left to software
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seconds_q <= 32'h0000_0000;
    end else if (wr && hit(avs_address_i, `RTC_OFS_SECONDS)) begin
      seconds_q <= avs_writedata_i;
    end else if (wrap) begin
      seconds_q <= seconds_q + 32'h0000_0001;
    end
  end

  // Time-of-day alarm fires as seconds reach the target
  assign tod_fire = wrap && tod_armed_q && ctrl_q[`RTC_CTRL_TOD_EN]
                    && ((seconds_q + 32'h0000_0001) == tod_alarm_q);

  // Writing the target also captures the distance used for repeats
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tod_alarm_q  <= 32'h0000_0000;
      tod_period_q <= 32'h0000_0000;
      tod_armed_q  <= 1'b0;
    end else if (wr && hit(avs_address_i, `RTC_OFS_TOD_ALARM)) begin
      tod_alarm_q  <= avs_writedata_i;
      tod_period_q <= avs_writedata_i - seconds_q;
      tod_armed_q  <= 1'b1;
    end else if (tod_fire) begin
      if (ctrl_q[`RTC_CTRL_TOD_RPT]) begin
        tod_alarm_q <= tod_alarm_q + tod_period_q;
      end else begin
        tod_armed_q <= 1'b0;
      end
    end
  end

  // Subsecond alarm fires on the tick taken while the down count is one
  assign ss_fire = tick && ss_armed_q && ctrl_q[`RTC_CTRL_SS_EN]
                   && (ss_count_q == 32'h0000_0001);

  // Down counter in 1/4096 s units; a zero reload never arms
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ss_reload_q <= 32'h0000_0000;
      ss_count_q  <= 32'h0000_0000;
      ss_armed_q  <= 1'b0;
    end else if (wr && hit(avs_address_i, `RTC_OFS_SS_ALARM)) begin
      ss_reload_q <= avs_writedata_i;
      ss_count_q  <= avs_writedata_i;
      ss_armed_q  <= (avs_writedata_i != 32'h0000_0000);
    end else if (ss_fire) begin
      ss_count_q <= ss_reload_q;
      ss_armed_q <= ctrl_q[`RTC_CTRL_SS_RPT];
    end else if (tick && ss_armed_q && ctrl_q[`RTC_CTRL_SS_EN]) begin
      ss_count_q <= ss_count_q - 32'h0000_0001;
    end
  end

  // Control register steers run, alarms, repeat, calibration and wake
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= `RTC_CTRL_RST;
    end else if (wr && hit(avs_address_i, `RTC_OFS_CTRL)) begin
      ctrl_q <= avs_writedata_i[`RTC_CTRL_W-1:0];
    end
  end

  // Trim register; -128 would exceed the range and is clamped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trim_q <= trim_t'(8'h00);
    end else if (wr && hit(avs_address_i, `RTC_OFS_TRIM)) begin
      trim_q <= clamp_trim(avs_writedata_i[7:0]);
    end
  end

  assign ev = {wrap, ss_fire, tod_fire};

  // Sticky status: an event in the clearing cycle survives the clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_q <= 3'h0;
    end else if (wr && hit(avs_address_i, `RTC_OFS_INT_CLR)) begin
      stat_q <= (stat_q & ~avs_writedata_i[`RTC_EV_W-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  // Interrupt enable mask
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_en_q <= 3'h0;
    end else if (wr && hit(avs_address_i, `RTC_OFS_INT_EN)) begin
      int_en_q <= avs_writedata_i[`RTC_EV_W-1:0];
    end
  end

  // Level outputs follow the sticky flags until software clears them
  assign irq_o  = |(stat_q & int_en_q);
  assign wake_o = (stat_q[`RTC_EV_TOD] & ctrl_q[`RTC_CTRL_TOD_WAKE])
                | (stat_q[`RTC_EV_SS] & ctrl_q[`RTC_CTRL_SS_WAKE]);

  // Read multiplexer; unmapped and write-only offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(avs_address_i, `RTC_OFS_SECONDS)) begin
      rd_mux = seconds_q;
    end else if (hit(avs_address_i, `RTC_OFS_SUBSEC)) begin
      rd_mux = {20'h00000, subsec_q};
    end else if (hit(avs_address_i, `RTC_OFS_TOD_ALARM)) begin
      rd_mux = tod_alarm_q;
    end else if (hit(avs_address_i, `RTC_OFS_SS_ALARM)) begin
      rd_mux = ss_count_q;
    end else if (hit(avs_address_i, `RTC_OFS_CTRL)) begin
      rd_mux = {24'h000000, ctrl_q};
    end else if (hit(avs_address_i, `RTC_OFS_TRIM)) begin
      rd_mux = {{24{trim_q[7]}}, trim_q};
    end else if (hit(avs_address_i, `RTC_OFS_INT_STAT)) begin
      rd_mux = {29'h0000_0000, stat_q};
    end else if (hit(avs_address_i, `RTC_OFS_INT_EN)) begin
      rd_mux = {29'h0000_0000, int_en_q};
    end
  end

  // Read data captured in the wait cycle, stands in the answer cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // Checks on the block's own behaviour
  sequence s_req_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence

  sequence s_req_done;
    (avs_read_i || avs_write_i) && !avs_waitrequest_o;
  endsequence

  property p_bus_answer;
    @(posedge clk_i) disable iff (rst_i)
    s_req_wait |=> s_req_done or !(avs_read_i || avs_write_i);
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  property p_sec_carry;
    @(posedge clk_i) disable iff (rst_i)
    (wrap && !wr) |=> (seconds_q == $past(seconds_q) + 32'h0000_0001) && (subsec_q == 12'h000);
  endproperty
  a_sec_carry: assert property (p_sec_carry) else $error("seconds carry wrong");

  property p_sub_step;
    @(posedge clk_i) disable iff (rst_i)
    (tick && !wr) |=> subsec_q == $past(subsec_q) + 12'h001;
  endproperty
  a_sub_step: assert property (p_sub_step) else $error("subsecond step wrong");

  property p_tod_flag;
    @(posedge clk_i) disable iff (rst_i)
    tod_fire |=> stat_q[`RTC_EV_TOD] && (seconds_q == tod_alarm_q || ctrl_q[`RTC_CTRL_TOD_RPT] || wr);
  endproperty
  a_tod_flag: assert property (p_tod_flag) else $error("time alarm not flagged");

  property p_ss_flag;
    @(posedge clk_i) disable iff (rst_i)
    ss_fire |=> stat_q[`RTC_EV_SS];
  endproperty
  a_ss_flag: assert property (p_ss_flag) else $error("subsecond alarm not flagged");

  property p_repeat;
    @(posedge clk_i) disable iff (rst_i)
    (ss_fire && ctrl_q[`RTC_CTRL_SS_RPT] && !wr) |=> ss_armed_q && ss_count_q == ss_reload_q;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat did not reload");

  // A one-shot subsecond alarm must not fire a second time
  property p_ss_once;
    @(posedge clk_i) disable iff (rst_i)
    (ss_fire && !ctrl_q[`RTC_CTRL_SS_RPT] && !wr) |=> !ss_armed_q;
  endproperty
  a_ss_once: assert property (p_ss_once) else $error("one-shot alarm still armed");

  // A repeating time alarm moves its target on by the captured period
  property p_tod_repeat;
    @(posedge clk_i) disable iff (rst_i)
    (tod_fire && ctrl_q[`RTC_CTRL_TOD_RPT] && !wr)
      |=> tod_armed_q && (tod_alarm_q == $past(tod_alarm_q) + tod_period_q);
  endproperty
  a_tod_repeat: assert property (p_tod_repeat) else $error("time alarm did not advance");

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    (ss_fire && int_en_q[`RTC_EV_SS] && !wr) |=> irq_o [*2];
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_sticky;
    @(posedge clk_i) disable iff (rst_i)
    (stat_q[`RTC_EV_TOD] && !(wr && hit(avs_address_i, `RTC_OFS_INT_CLR))) |=> stat_q[`RTC_EV_TOD];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status flag lost");

  property p_trim_range;
    @(posedge clk_i) disable iff (rst_i)
    trim_q != trim_t'(8'h80);
  endproperty
  a_trim_range: assert property (p_trim_range) else $error("trim out of range");

  property p_cal_toggle;
    @(posedge clk_i) disable iff (rst_i)
    (tick && ctrl_q[`RTC_CTRL_CAL_EN] && calibration_square_output_oe_o)
      |=> calibration_square_output_o != $past(calibration_square_output_o);
  endproperty
  a_cal_toggle: assert property (p_cal_toggle) else $error("calibration output stuck");

endmodule : rtc_alarm_calibration
`default_nettype wire

/* src/rtc_cal_out.sv */
// Purpose: Square calibration output at half the trimmed tick rate
// Assumes: tick is a one-cycle pulse at 4096 Hz
// Notes:   Output idles low while disabled so a meter sees a clean start
`timescale 1ns/10ps
`default_nettype none
module rtc_cal_out (
  input  wire logic clk_i,
  input  wire logic rst_i,
  rtc_tick_if.cal   tb,
  output logic      sq_o,
  output logic      oe_o
);
  import rtc_pkg::*;
  // Toggle on every trimmed tick gives a 2048 Hz square wave
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sq_o <= 1'b0;
      oe_o <= 1'b0;
    end else begin
      oe_o <= tb.cal_en;
      if (!tb.cal_en) begin
        sq_o <= 1'b0;
      end else if (tb.tick) begin
        sq_o <= ~sq_o;
      end
    end
  end
endmodule : rtc_cal_out
`default_nettype wire

/* src/rtc_params.svh */
// Purpose: Offsets, fields, reset values and timing counts of the real-time clock
// Assumes: Byte addresses on a 32-bit Avalon-MM slave
// Notes:   Included by its bare name
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH
`define RTC_OFS_SECONDS    6'h00
`define RTC_OFS_SUBSEC     6'h04
`define RTC_OFS_TOD_ALARM  6'h08
`define RTC_OFS_SS_ALARM   6'h0C
`define RTC_OFS_CTRL       6'h10
`define RTC_OFS_TRIM       6'h14
`define RTC_OFS_INT_STAT   6'h18
`define RTC_OFS_INT_CLR    6'h1C
`define RTC_OFS_INT_EN     6'h20
`define RTC_CTRL_RUN       0
`define RTC_CTRL_TOD_EN    1
`define RTC_CTRL_SS_EN     2
`define RTC_CTRL_TOD_RPT   3
`define RTC_CTRL_SS_RPT    4
`define RTC_CTRL_CAL_EN    5
`define RTC_CTRL_TOD_WAKE  6
`define RTC_CTRL_SS_WAKE   7
`define RTC_CTRL_W         8
`define RTC_CTRL_RST       8'h01
`define RTC_EV_TOD         0
`define RTC_EV_SS          1
`define RTC_EV_SEC         2
`define RTC_EV_W           3
`define RTC_SUB_W          12
`define RTC_SUB_LAST       12'hFFF
`define RTC_PRE_W          3
`define RTC_PPM_DEN        20'hF4240
`define RTC_PPM_W          20
`define RTC_TRIM_MAX       8'h7F
`define RTC_TRIM_MIN       8'h81
`endif

/* src/rtc_pkg.sv */
// Purpose: Types shared by the real-time clock modules
// Assumes: Constants come from rtc_params.svh
// Notes:   None
package rtc_pkg;
  typedef logic signed [7:0] trim_t;
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;
endpackage : rtc_pkg

/* src/rtc_tick_gen.sv */
// Purpose: Divides 32.768 kHz edges to a trimmed 4096 Hz tick
// Assumes: edge_32k is a one-cycle pulse per time-base period
// Notes:   Each trim step adds or drops one time-base edge per million on average
`timescale 1ns/10ps
`default_nettype none
`include "rtc_params.svh"
module rtc_tick_gen (
  input  wire logic clk_i,
  input  wire logic rst_i,
  rtc_tick_if.gen   tb
);
  import rtc_pkg::*;
  logic [`RTC_PRE_W-1:0] pre_q;
  logic [`RTC_PPM_W-1:0] acc_q;
  logic [`RTC_PPM_W-1:0] mag;
  logic [`RTC_PPM_W:0]   acc_sum;
  logic                  fix;
  logic [`RTC_PRE_W:0]   pre_sum;
  // Magnitude of trim; sign picks add or drop
  assign mag     = {12'h000, (tb.trim[7] ? 8'(-tb.trim) : 8'(tb.trim))};
  assign acc_sum = {1'b0, acc_q} + {1'b0, mag};
  assign fix     = acc_sum >= {1'b0, `RTC_PPM_DEN};
  // Positive trim steps twice, negative trim holds one edge
  assign pre_sum = {1'b0, pre_q} + (fix ? (tb.trim[7] ? 4'h0 : 4'h2) : 4'h1);
  // Prescaler wraps every eight edges; a trim correction makes it seven or nine
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_q <= 3'h0;
      tb.tick <= 1'b0;
    end else begin
      tb.tick <= tb.edge_32k & pre_sum[`RTC_PRE_W];
      if (tb.edge_32k) begin
        pre_q <= pre_sum[`RTC_PRE_W-1:0];
      end
    end
  end
  // Parts-per-million accumulator
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q <= 20'h00000;
    end else if (tb.edge_32k) begin
      acc_q <= fix ? `RTC_PPM_W'(acc_sum - {1'b0, `RTC_PPM_DEN}) : acc_sum[`RTC_PPM_W-1:0];
    end
  end
endmodule : rtc_tick_gen
`default_nettype wire

/* src/rtc_tick_if.sv */
// Purpose: Carries time-base edges, trim and the 4096 Hz tick between modules
// Assumes: One clock domain
// Notes:   None
`timescale 1ns/10ps
`default_nettype none
interface rtc_tick_if;
  logic                 edge_32k;
  rtc_pkg::trim_t       trim;
  logic                 tick;
  logic                 cal_en;
  modport gen (input edge_32k, input trim, output tick);
  modport cal (input tick, input cal_en);
  modport top (output edge_32k, output trim, output cal_en, input tick);
endinterface : rtc_tick_if
`default_nettype wire

/* tb/rtc_time_base.sv */
// Purpose: Behavioural 32.768 kHz time-base source for the real-time clock
// Assumes: Timescale of 1 ns; the half period is scaled down to keep runs short
// Notes:   Start offset keeps source edges away from system clock edges
`timescale 1ns/10ps
`default_nettype none
module rtc_time_base #(
  parameter int HALF_NS  = 100,
  parameter int START_NS = 7
) (
  input  wire logic run_i,
  output logic      clk32_o
);
  // Square wave while the source runs; low while stopped, never a stale level
  initial begin
    clk32_o = 1'b0;
    #(START_NS);
    forever begin
      #(HALF_NS);
      clk32_o = run_i ? ~clk32_o : 1'b0;
    end
  end
endmodule : rtc_time_base
`default_nettype wire

/* tb/tb_rtc_alarm_calibration.sv */
// Purpose: Self-checking bench for the real-time clock with alarms and trim
// Assumes: Time base runs at 8 system clocks a period so a second is 4096 ticks of 64 clocks
// Notes:   Seconds are reached by loading the subsecond count near its wrap
`timescale 1ns/10ps
`default_nettype none
`include "rtc_params.svh"
module tb_rtc_alarm_calibration;
  logic        clk_i           = 1'b0;
  logic        rst_i           = 1'b1;
  logic [5:0]  avs_address_i   = 6'h00;
  logic        avs_read_i      = 1'b0;
  logic        avs_write_i     = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic        base_run        = 1'b1;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        rtc_clk_i;
  logic        irq_o;
  logic        wake_o;
  logic        sq;
  logic        oe;
  logic [31:0] rd;
  int          fails           = 0;
  int          checks_done     = 0;
  int          n;

  // System clock, 25 ns period
  always #12.5 clk_i = ~clk_i;

  rtc_alarm_calibration u_rtc_alarm_calibration (
    .clk_i                          (clk_i),
    .rst_i                          (rst_i),
    .avs_address_i                  (avs_address_i),
    .avs_read_i                     (avs_read_i),
    .avs_write_i                    (avs_write_i),
    .avs_writedata_i                (avs_writedata_i),
    .avs_readdata_o                 (avs_readdata_o),
    .avs_waitrequest_o              (avs_waitrequest_o),
    .rtc_clk_i                      (rtc_clk_i),
    .irq_o                          (irq_o),
    .wake_o                         (wake_o),
    .calibration_square_output_o    (sq),
    .calibration_square_output_oe_o (oe)
  );

  rtc_time_base u_rtc_time_base (
    .run_i   (base_run),
    .clk32_o (rtc_clk_i)
  );

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_bit

  // One bus access; request held until waitrequest is sampled low,
  // only the watchdog ends a hung wait; the slave inserts one wait cycle
  task automatic bus_xfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    do begin
      @(posedge clk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    check_bit(avs_waitrequest_o, 1'b0);
    check_word(32'(k), 32'h2);
  endtask : bus_xfer

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus_xfer(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    bus_xfer(1'b0, a, 32'h0);
    check_word(rd, exp);
  endtask : rdchk

  // Bounded wait for the interrupt line; an edge passes first so that a
  // clear issued at the previous edge has landed before irq is looked at
  task automatic wait_irq(input int lim);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (irq_o !== 1'b1 && n < lim);
  endtask : wait_irq

  task automatic t_reset;
    check_bit(irq_o, 1'b0);
    check_bit(oe, 1'b0);
    rdchk(`RTC_OFS_CTRL, 32'h1);
    rdchk(`RTC_OFS_SECONDS, 32'h0);
    rdchk(`RTC_OFS_INT_STAT, 32'h0);
    rdchk(`RTC_OFS_INT_CLR, 32'h0);
    rdchk(6'h3C, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    logic [31:0] tw [4];
    logic [31:0] te [4];
    tw = '{32'h7F, 32'h81, 32'h80, 32'hFF};
    te = '{32'h7F, 32'hFFFFFF81, 32'hFFFFFF81, 32'hFFFFFFFF};
    wr(`RTC_OFS_SECONDS, 32'hFFFFFFFE);
    rdchk(`RTC_OFS_SECONDS, 32'hFFFFFFFE);
    for (int i = 0; i < 4; i++) begin
      wr(`RTC_OFS_TRIM, tw[i]);
      rdchk(`RTC_OFS_TRIM, te[i]);
    end
    wr(`RTC_OFS_TRIM, 32'h0);
    wr(`RTC_OFS_INT_EN, 32'h7);
    rdchk(`RTC_OFS_INT_EN, 32'h7);
    $display("test registers done");
  endtask : t_regs

  // Subsecond wrap carries into seconds and raises the sticky seconds flag
  task automatic t_carry;
    wr(`RTC_OFS_CTRL, 32'h0);
    wr(`RTC_OFS_SECONDS, 32'h5);
    wr(`RTC_OFS_SUBSEC, 32'hFF0);
    wr(`RTC_OFS_INT_CLR, 32'h7);
    wr(`RTC_OFS_INT_EN, 32'h4);
    repeat (200) @(posedge clk_i);
    rdchk(`RTC_OFS_SUBSEC, 32'hFF0);
    wr(`RTC_OFS_CTRL, 32'h1);
    wait_irq(1500);
    check_bit(irq_o, 1'b1);
    rdchk(`RTC_OFS_SECONDS, 32'h6);
    repeat (100) @(posedge clk_i);
    rdchk(`RTC_OFS_INT_STAT, 32'h4);
    check_bit(wake_o, 1'b0);
    wr(`RTC_OFS_INT_CLR, 32'h4);
    rdchk(`RTC_OFS_INT_STAT, 32'h0);
    check_bit(irq_o, 1'b0);
    $display("test carry done");
  endtask : t_carry

  task automatic t_tod;
    wr(`RTC_OFS_CTRL, 32'h0);
    wr(`RTC_OFS_SECONDS, 32'hA);
    wr(`RTC_OFS_SUBSEC, 32'hFF0);
    wr(`RTC_OFS_TOD_ALARM, 32'hB);
    wr(`RTC_OFS_INT_CLR, 32'h7);
    wr(`RTC_OFS_INT_EN, 32'h1);
    wr(`RTC_OFS_CTRL, 32'h4B);
    wait_irq(1500);
    check_bit(n > 900, 1'b1);
    check_bit(irq_o, 1'b1);
    check_bit(wake_o, 1'b1);
    rdchk(`RTC_OFS_SECONDS, 32'hB);
    wr(`RTC_OFS_INT_CLR, 32'h1);
    @(posedge clk_i);
    check_bit(irq_o, 1'b0);
    check_bit(wake_o, 1'b0);
    wr(`RTC_OFS_SUBSEC, 32'hFF0);
    wait_irq(1500);
    check_bit(irq_o, 1'b1);
    rdchk(`RTC_OFS_SECONDS, 32'hC);
    wr(`RTC_OFS_INT_CLR, 32'h1);
    wr(`RTC_OFS_CTRL, 32'h1);
    $display("test time-of-day alarm done");
  endtask : t_tod

  task automatic t_ss;
    wr(`RTC_OFS_INT_CLR, 32'h7);
    wr(`RTC_OFS_INT_EN, 32'h2);
    wr(`RTC_OFS_CTRL, 32'h5);
    wr(`RTC_OFS_SS_ALARM, 32'h3);
    wait_irq(400);
    check_bit(n >= 120 && n <= 200, 1'b1);
    bus_xfer(1'b0, `RTC_OFS_INT_STAT, 32'h0);
    check_word(rd & 32'h3, 32'h2);
    wr(`RTC_OFS_INT_CLR, 32'h2);
    wait_irq(400);
    check_bit(irq_o, 1'b0);
    wr(`RTC_OFS_CTRL, 32'h95);
    wr(`RTC_OFS_SS_ALARM, 32'h2);
    wait_irq(300);
    check_bit(irq_o, 1'b1);
    check_bit(wake_o, 1'b1);
    wr(`RTC_OFS_INT_CLR, 32'h2);
    wait_irq(300);
    check_bit(irq_o, 1'b1);
    wr(`RTC_OFS_CTRL, 32'h1);
    wr(`RTC_OFS_INT_CLR, 32'h7);
    $display("test subsecond alarm done");
  endtask : t_ss

  // Half period of the square output equals one tick, 64 clocks at zero trim
  task automatic t_cal;
    wr(`RTC_OFS_CTRL, 32'h21);
    repeat (2) @(posedge clk_i);
    check_bit(oe, 1'b1);
    n = 0;
    while (sq !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (sq === 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    check_word(32'(n), 32'h40);
    wr(`RTC_OFS_CTRL, 32'h1);
    repeat (2) @(posedge clk_i);
    check_bit(oe, 1'b0);
    check_bit(sq, 1'b0);
    $display("test calibration output done");
  endtask : t_cal

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_carry();
    t_tod();
    t_ss();
    t_cal();
    report_and_stop();
  end

  // Watchdog well beyond the roughly 5k cycles the tests need
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    report_and_stop();
  end
endmodule : tb_rtc_alarm_calibration
`default_nettype wire
